/* File: rtl/swcl_link.sv */
// serial-clock side: shift register and daisy-chain bit
module swcl_link
    import swcl_pkg::*;
(
    input wire logic linkClk,
    input wire logic linkRstN,
    input wire logic chipSelN,
    input wire logic serialIn,
    output logic [WORD_BITS-1:0] shiftWord,
    output logic chainBit
);
    logic [WORD_BITS-1:0] shift_q; // serial input register
    logic chainBit_q; // daisy-chain output latch

    // shift one bit in per rising edge while selected, msb first
    always_ff @(posedge linkClk or negedge linkRstN) begin
        if (!linkRstN) begin
            shift_q <= '0;
        end else if (!chipSelN) begin
            shift_q <= {shift_q[WORD_BITS-2:0], serialIn};
        end
    end

    // bit leaving the far end, entered ten shifts earlier
    always_ff @(posedge linkClk or negedge linkRstN) begin
        if (!linkRstN) begin
            chainBit_q <= 1'b0;
        end else if (!chipSelN) begin
            chainBit_q <= shift_q[WORD_BITS-1];
        end
    end

    assign shiftWord = shift_q;
    assign chainBit = chainBit_q;
endmodule : swcl_link

/* File: rtl/swcl_pkg.sv */
// constants shared by the serial wiper code loader
package swcl_pkg;
    // serial word layout
    localparam int WORD_BITS = 10;
    localparam int SEL_BITS = 2;
    localparam int CODE_BITS = 8;
    localparam int SEL_MSB = 9;
    localparam int SEL_LSB = 8;
    localparam int CODE_MSB = 7;
    localparam int CODE_LSB = 0;
    // channel counts
    localparam int MAX_CHANNELS = 4;
    localparam int DEF_CHANNELS = 4;
    // reset and tap values
    localparam logic [7:0] MIDSCALE_CODE = 8'h80;
    localparam logic [7:0] END_LOW_CODE = 8'h00;
    localparam int TAP_COUNT = 256;
    // timing of the serial link
    localparam int MCLK_FREQ_MHZ = 100;
    localparam int LINK_MAX_FREQ_MHZ = 10;
    localparam int LINK_MIN_PERIOD_NS = 100;
    localparam int MCLK_PERIOD_NS = 1000 / MCLK_FREQ_MHZ;
    localparam int LINK_MIN_PERIOD_CYC = (LINK_MIN_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    // synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage : swcl_pkg

/* File: rtl/swcl_top.sv */
// top of the serial wiper code loader: latches, shutdown and link crossing
// Notes on behaviour
// - ten-bit word: two select bits, eight code
// - channel number is select value plus one
// - channels load individually in any order
// - link clock up to 10 MHz
// - reset puts every latch at midscale 128
// - shutdown opens high end, wiper to low
// - shutdown keeps latches, release restores taps
// - shutdown keeps loading, chain output off
// - codes loaded in shutdown apply after release
// - code selects tap, zero at low end
// - shift in one bit per rising edge
// - chip select rise loads decoded channel latch
// - chain output delays input by ten shifts
// - reset forces midscale and clears chain latch
module swcl_top
    import swcl_pkg::*;
#(
    parameter int CHANNELS = DEF_CHANNELS // 1, 2 or 4 channels built
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic linkClk,
    input wire logic chipSelN,
    input wire logic serialIn,
    input wire logic midscaleResetN,
    input wire logic powerDownN,
    output logic [CHANNELS*CODE_BITS-1:0] wiperLatch,
    output logic [CHANNELS*CODE_BITS-1:0] wiperTap,
    output logic endHighOpen,
    output logic wiperAtLow,
    output logic chainOut,
    output logic chainOutEn,
    output logic loadDone,
    output logic loadIgnored,
    output logic [SEL_BITS-1:0] lastSel
);
    // reset release synchroniser
    logic rstMeta_q; // first stage, read only by second
    logic rstSyncN_q; // released reset for the core

    // pin synchronisers into the mclk domain
    logic csMeta_q; // chip select, first stage
    logic csSync_q; // chip select, second stage
    logic csPrev_q; // chip select, previous value
    logic msrMeta_q; // midscale reset, first stage
    logic msrSync_q; // midscale reset, second stage
    logic pdMeta_q; // shutdown, first stage
    logic pdSync_q; // shutdown, second stage
    logic chainMeta_q; // chain bit, first stage
    logic chainSync_q; // chain bit, second stage
    logic [WORD_BITS-1:0] wordMeta_q; // shift word, first stage
    logic [WORD_BITS-1:0] wordSync_q; // shift word, second stage

    // load control
    logic csRise; // chip select just went high
    logic loadPend_q; // word settled, load on this cycle
    logic [SEL_BITS-1:0] selVal; // decoded select bits
    logic [CODE_BITS-1:0] codeVal; // decoded code bits
    logic selValid; // select addresses a built channel

    // link side
    logic linkRstN; // reset for link logic
    logic [WORD_BITS-1:0] shiftWord; // shift register contents
    logic chainBit; // daisy-chain output latch

    // output registers
    logic endHighOpen_q;
    logic wiperAtLow_q;
    logic chainOutEn_q;
    logic loadDone_q;
    logic loadIgnored_q;
    logic [SEL_BITS-1:0] lastSel_q;

    // link reset: either the core reset or the midscale pin
    assign linkRstN = reset_n & midscaleResetN;

    // serial-clock domain logic
    swcl_link u_link (
        .linkClk(linkClk),
        .linkRstN(linkRstN),
        .chipSelN(chipSelN),
        .serialIn(serialIn),
        .shiftWord(shiftWord),
        .chainBit(chainBit)
    );

    // release of the core reset through two flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_q <= 1'b0;
            rstSyncN_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSyncN_q <= rstMeta_q;
        end
    end

    // chip select crossing and edge history
    always_ff @(posedge mclk or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            csMeta_q <= 1'b1;
            csSync_q <= 1'b1;
            csPrev_q <= 1'b1;
        end else begin
            csMeta_q <= chipSelN;
            csSync_q <= csMeta_q;
            csPrev_q <= csSync_q;
        end
    end

    // midscale reset and shutdown pin crossings
    always_ff @(posedge mclk or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            msrMeta_q <= 1'b1;
            msrSync_q <= 1'b1;
            pdMeta_q <= 1'b1;
            pdSync_q <= 1'b1;
        end else begin
            msrMeta_q <= midscaleResetN;
            msrSync_q <= msrMeta_q;
            pdMeta_q <= powerDownN;
            pdSync_q <= pdMeta_q;
        end
    end

    // shift word and chain bit crossings; both hold still while select is high
    always_ff @(posedge mclk or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            wordMeta_q <= '0;
            wordSync_q <= '0;
            chainMeta_q <= 1'b0;
            chainSync_q <= 1'b0;
        end else begin
            wordMeta_q <= shiftWord;
            wordSync_q <= wordMeta_q;
            chainMeta_q <= chainBit;
            chainSync_q <= chainMeta_q;
        end
    end

    // end of frame seen on the synchronised select
    assign csRise = csSync_q & ~csPrev_q;

    // wait one more cycle so the word copy has surely settled
    always_ff @(posedge mclk or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            loadPend_q <= 1'b0;
        end else begin
            loadPend_q <= csRise;
        end
    end

    // word decode: select bits on top, code below
    assign selVal = wordSync_q[SEL_MSB:SEL_LSB];
    assign codeVal = wordSync_q[CODE_MSB:CODE_LSB];
    assign selValid = ({1'b0, selVal} < (SEL_BITS+1)'(CHANNELS));

    // one latch per built channel
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            logic [CODE_BITS-1:0] latch_q; // wiper latch
            logic [CODE_BITS-1:0] tap_q; // tap actually selected

            // latch loads only on its own select value
            always_ff @(posedge mclk or negedge rstSyncN_q) begin
                if (!rstSyncN_q) begin
                    latch_q <= MIDSCALE_CODE;
                end else if (!msrSync_q) begin
                    latch_q <= MIDSCALE_CODE;
                end else if (loadPend_q && selVal == SEL_BITS'(ch)) begin
                    latch_q <= codeVal;
                end
            end

            // tap follows the latch, pinned to the low end in shutdown
            always_ff @(posedge mclk or negedge rstSyncN_q) begin
                if (!rstSyncN_q) begin
                    tap_q <= MIDSCALE_CODE;
                end else if (!pdSync_q) begin
                    tap_q <= END_LOW_CODE;
                end else begin
                    tap_q <= latch_q;
                end
            end

            assign wiperLatch[ch*CODE_BITS +: CODE_BITS] = latch_q;
            assign wiperTap[ch*CODE_BITS +: CODE_BITS] = tap_q;
        end
    endgenerate

    // shutdown switches: high end open, wiper tied low
    always_ff @(posedge mclk or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            endHighOpen_q <= 1'b0;
            wiperAtLow_q <= 1'b0;
        end else begin
            endHighOpen_q <= ~pdSync_q;
            wiperAtLow_q <= ~pdSync_q;
        end
    end

    // open-drain chain pin: pull low for a zero, released in shutdown or reset
    always_ff @(posedge mclk or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            chainOutEn_q <= 1'b0;
        end else begin
            chainOutEn_q <= pdSync_q & msrSync_q & ~chainSync_q;
        end
    end

    // load status: pulse per frame, ignored when channel not built
    always_ff @(posedge mclk or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            loadDone_q <= 1'b0;
            loadIgnored_q <= 1'b0;
            lastSel_q <= '0;
        end else begin
            loadDone_q <= loadPend_q & msrSync_q & selValid;
            loadIgnored_q <= loadPend_q & msrSync_q & ~selValid;
            if (loadPend_q && msrSync_q) begin
                lastSel_q <= selVal;
            end
        end
    end

    // outputs straight from flops
    assign endHighOpen = endHighOpen_q;
    assign wiperAtLow = wiperAtLow_q;
    assign chainOut = chainBit;
    assign chainOutEn = chainOutEn_q;
    assign loadDone = loadDone_q;
    assign loadIgnored = loadIgnored_q;
    assign lastSel = lastSel_q;
endmodule : swcl_top

/* File: sim/swcl_host.sv */
// host serial master model driving the link pins
module swcl_host
    import swcl_pkg::*;
(
    output logic linkClk,
    output logic chipSelN,
    output logic serialIn,
    input wire logic chainOut
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [WORD_BITS-1:0] seen; // chain bits seen in last frame
    // idle pins, clock stands low
    initial begin
        linkClk = 1'b0;
        chipSelN = 1'b1;
        serialIn = 1'b0;
    end
    // one frame at 80 ns, msb first
    task automatic send(input logic [WORD_BITS-1:0] w);
        #7 chipSelN = 1'b0;
        for (int i = WORD_BITS - 1; i >= 0; i--) begin
            serialIn = w[i];
            #40 linkClk = 1'b1;
            #1 seen[i] = chainOut;
            #39 linkClk = 1'b0;
        end
        #40 chipSelN = 1'b1;
        serialIn = ~serialIn; // released line keeps no stale bit
    endtask : send
endmodule : swcl_host

/* File: sim/swcl_top_asserts.sv */
// checker on the top ports of the serial wiper code loader
module swcl_top_asserts
    import swcl_pkg::*;
#(
    parameter int CHANNELS = DEF_CHANNELS // channels built
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic linkClk,
    input wire logic chipSelN,
    input wire logic serialIn,
    input wire logic midscaleResetN,
    input wire logic powerDownN,
    input wire logic [CHANNELS*CODE_BITS-1:0] wiperLatch,
    input wire logic [CHANNELS*CODE_BITS-1:0] wiperTap,
    input wire logic endHighOpen,
    input wire logic wiperAtLow,
    input wire logic chainOut,
    input wire logic chainOutEn,
    input wire logic loadDone,
    input wire logic loadIgnored,
    input wire logic [SEL_BITS-1:0] lastSel
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // frame closed while not in midscale reset
    sequence frameEnd;
        $rose(chipSelN) && midscaleResetN;
    endsequence
    // one answer pulse a few cycles later
    sequence answered;
        ##[3:6] (loadDone || loadIgnored);
    endsequence
    AST_FRAME_ANSWER: assert property (frameEnd |-> answered) else $error("frame not answered");
    AST_DONE_SEL: assert property (loadDone |-> lastSel < CHANNELS) else $error("load of absent channel");
    AST_IGNORE_SEL: assert property (loadIgnored |-> lastSel >= CHANNELS && $stable(wiperLatch))
        else $error("bad refusal");
    AST_ONE_ANSWER: assert property (!(loadDone && loadIgnored)) else $error("two answers");
    AST_POWER_DOWN_N_ENTER: assert property ($fell(powerDownN) |-> ##[2:3] (endHighOpen && wiperAtLow))
        else $error("shutdown late");
    AST_POWER_DOWN_N_TAP: assert property (wiperAtLow |-> endHighOpen && wiperTap == '0) else $error("tap in shutdown");
    AST_TAP_FOLLOW: assert property (!wiperAtLow |-> wiperTap == $past(wiperLatch))
        else $error("tap not latch");
    AST_CHAIN_OFF: assert property (endHighOpen |-> !chainOutEn) else $error("chain driven in shutdown");
    AST_MID_LATCH: assert property ($fell(midscaleResetN) |-> ##[2:4] wiperLatch == {CHANNELS{MIDSCALE_CODE}})
        else $error("no midscale");
    AST_MID_CHAIN: assert property (!midscaleResetN |-> !chainOut) else $error("chain not cleared");
endmodule : swcl_top_asserts

bind swcl_top swcl_top_asserts #(.CHANNELS(CHANNELS)) u_asserts (.mclk(mclk), .reset_n(reset_n),
    .linkClk(linkClk), .chipSelN(chipSelN), .serialIn(serialIn), .midscaleResetN(midscaleResetN),
    .powerDownN(powerDownN), .wiperLatch(wiperLatch), .wiperTap(wiperTap), .endHighOpen(endHighOpen),
    .wiperAtLow(wiperAtLow), .chainOut(chainOut), .chainOutEn(chainOutEn), .loadDone(loadDone),
    .loadIgnored(loadIgnored), .lastSel(lastSel));

/* File: sim/swcl_top_tb_top.sv */
// testbench for the serial wiper code loader
module swcl_top_tb_top
    import swcl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NCH = 2; // dual variant
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic midscaleResetN = 1'b1;
    logic powerDownN = 1'b1;
    logic linkClk, chipSelN, serialIn, chainOut, chainOutEn, endHighOpen, wiperAtLow, loadDone, loadIgnored;
    logic [NCH*CODE_BITS-1:0] wiperLatch, wiperTap, expLatch;
    logic [SEL_BITS-1:0] lastSel;
    logic [1:0] ans; // {done, ignored}
    int error_cnt = 0;
    int total_checks = 0;
    // core clock
    always #5 mclk = ~mclk;
    swcl_host HOST (.linkClk(linkClk), .chipSelN(chipSelN), .serialIn(serialIn), .chainOut(chainOut));
    swcl_top #(.CHANNELS(NCH)) DUT (.mclk(mclk), .reset_n(reset_n), .linkClk(linkClk), .chipSelN(chipSelN),
        .serialIn(serialIn), .midscaleResetN(midscaleResetN), .powerDownN(powerDownN), .wiperLatch(wiperLatch),
        .wiperTap(wiperTap), .endHighOpen(endHighOpen), .wiperAtLow(wiperAtLow), .chainOut(chainOut),
        .chainOutEn(chainOutEn), .loadDone(loadDone), .loadIgnored(loadIgnored), .lastSel(lastSel));
    // compare and count
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // one word, then collect the answer pulse
    task automatic frame(input logic [1:0] sel, input logic [7:0] code);
        ans = 2'b00;
        HOST.send({sel, code});
        repeat (12) begin
            @(posedge mclk);
            #1 ans = ans | {loadDone, loadIgnored};
        end
    endtask : frame
    // wait n cycles, land just after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    // main sequence
    initial begin
        cyc(4);
        reset_n = 1'b1;
        cyc(4);
        expLatch = {NCH{MIDSCALE_CODE}};
        chk(wiperLatch, expLatch);
        // every select, high first; absent channels refused
        for (int s = 3; s >= 0; s--) begin
            frame(2'(s), {4{2'(s)}});
            if (s < NCH) expLatch[s*8 +: 8] = {4{2'(s)}};
            chk(ans, (s < NCH) ? 24'h2 : 24'h1);
            chk(lastSel, 24'(s));
            chk(wiperLatch, expLatch);
            chk(wiperTap, expLatch);
        end
        frame(2'b01, 8'hC3);
        chk({chainOut, chainOutEn}, 24'h1);
        frame(2'b00, 8'h97);
        chk(HOST.seen, 10'h1C3);
        expLatch = 16'hC397;
        powerDownN = 1'b0;
        cyc(5);
        frame(2'b01, 8'h5A);
        expLatch[15:8] = 8'h5A;
        chk(wiperLatch, expLatch);
        chk({endHighOpen, wiperAtLow, chainOutEn, wiperTap}, 24'h60000);
        powerDownN = 1'b1;
        cyc(5);
        chk({endHighOpen, wiperAtLow, wiperTap}, {2'b00, expLatch});
        midscaleResetN = 1'b0;
        cyc(6);
        chk({chainOut, wiperLatch}, {1'b0, {NCH{MIDSCALE_CODE}}});
        midscaleResetN = 1'b1;
        cyc(5);
        finish_test();
    end
    // watchdog against a hang
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
endmodule : swcl_top_tb_top
